// ===== adgen_pkg.sv
// Shared constants and types for the address generation unit
package adgen_pkg;

  localparam int ADDR_W = 16;
  localparam int SHORT_W = 6;

  // Register selects on the core global data bus
  localparam logic [2:0] SEL_PTR0 = 3'h0;
  localparam logic [2:0] SEL_PTR3 = 3'h3;
  localparam logic [2:0] SEL_STACK = 3'h4;
  localparam logic [2:0] SEL_OFFSET = 3'h5;
  localparam logic [2:0] SEL_MODIFIER = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;
  localparam int NUM_PTR = 5;

  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] MOD_LINEAR = 16'hFFFF;

  // Highest on-chip data address reachable by the secondary bus
  localparam logic [15:0] XDATA_ONCHIP_TOP = 16'h07FF;

  localparam logic [15:0] STEP_INC = 16'h0001;
  localparam logic [15:0] STEP_DEC = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_NOUPD = 3'h0,
    MODE_POSTINC = 3'h1,
    MODE_POSTDEC = 3'h2,
    MODE_POSTOFF = 3'h3,
    MODE_IDXREG = 3'h4,
    MODE_IDXSHORT = 3'h5,
    MODE_IDXLONG = 3'h6,
    MODE_RSVD = 3'h7
  } adgen_mode_t;

  typedef enum logic [1:0] {
    TGT_NONE = 2'h0,
    TGT_XDATA = 2'h1,
    TGT_PROG = 2'h2,
    TGT_RSVD = 2'h3
  } adgen_tgt_t;

endpackage

// ===== adgen_modulo.sv
// Modulo arithmetic unit: linear or modulo pointer update
`timescale 1ns/1ns
`default_nettype none
module adgen_modulo
(
  // Operands
  input wire logic [15:0] ptr_in,
  input wire logic [15:0] step_in,
  input wire logic [15:0] modifier_in,
  input wire logic use_mod_in,
  // Results
  output logic [15:0] result_out,
  output logic [15:0] mask_out
);
  logic [15:0] linear;
  logic [15:0] offs;
  logic [15:0] sum;
  logic [16:0] size;
  logic [15:0] neg_mag;
  logic [15:0] fixed;

  // Buffer window spans the smallest power of two covering the modifier
  genvar b;
  generate
    for (b = 0; b < adgen_pkg::ADDR_W; b++)
    begin : g_mask
      assign mask_out[b] = |modifier_in[15:b];
    end
  endgenerate

  assign linear = ptr_in + step_in;
  assign offs = ptr_in & mask_out;
  assign sum = offs + step_in;
  assign size = {1'b0, modifier_in} + 17'h00001;
  assign neg_mag = 16'h0000 - step_in;

  // Wrap once by the buffer length; exact while the step stays within one buffer length
  always_comb
  begin
    fixed = sum;
    if (step_in[15])
    begin
      if (offs < neg_mag)
        fixed = sum + size[15:0];
    end
    else if ({1'b0, sum} > {1'b0, modifier_in})
    begin
      fixed = sum - size[15:0];
    end
  end

  assign result_out = use_mod_in ? ((ptr_in & ~mask_out) | (fixed & mask_out)) : linear;

endmodule // adgen_modulo
`default_nettype wire

// ===== adgen_incdec.sv
// Linear incrementer/decrementer for the dual-read pointer
`timescale 1ns/1ns
`default_nettype none
module adgen_incdec
(
  // Operand
  input wire logic [15:0] ptr_in,
  input wire logic dec_in,
  // Result
  output logic [15:0] result_out
);
  // No modulo here: keeps the second path short
  assign result_out = ptr_in + (dec_in ? adgen_pkg::STEP_DEC : adgen_pkg::STEP_INC);

endmodule // adgen_incdec
`default_nettype wire

// ===== adgen_core.sv
// Address generation unit: pointers, buses, update logic
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Four 16-bit pointers, each readable, writable and usable as bus address.
// - Up to two addresses and two updates per instruction for dual reads.
// - Primary data and program buses carry full 16-bit unsigned addresses.
// - Secondary bus addresses only reach on-chip data memory.
// - Primary operand via primary bus, second operand via secondary bus.
// - Offset serves all pointers and stack; modifier serves pointer zero, optionally one.
// - Pointer three updated by incrementer/decrementer on dual-read instructions.
// - Moved pointer, stack or modifier value usable from second following instruction.
// - Stack pointer used by push and pop, post-decremented on pop.
// - Any pointer feeds the modulo unit; result writes back to any pointer.
// - Post-update modes drive old pointer, then store updated value.
// - Program-memory data accesses use program bus and post-update pointer.
// - Counter step for normalization and conditional pointer transfer.
// - Indirect: no update, post inc/dec/offset, index by register, 6 or 16 bits.
// - Data bus reaches registers; three address buses leave the unit.
// - Integer address arithmetic in parallel, adding no cycles.
// - Modulo update wraps pointer within modifier plus one.
// - Modifier resets to all ones, meaning linear arithmetic.
module adgen_core
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Instruction cycle strobe
  input wire logic instr_en_in,
  // Core global data bus access
  input wire logic gdb_wr_en_in,
  input wire logic gdb_rd_en_in,
  input wire logic [2:0] gdb_sel_in,
  input wire logic [15:0] gdb_wdata_in,
  output logic [15:0] gdb_rdata_out,
  output logic gdb_rdata_valid_out,
  // Address operation from the decoder
  input wire logic op_valid_in,
  input wire logic [2:0] op_mode_in,
  input wire logic [1:0] op_target_in,
  input wire logic [2:0] op_ptr_in,
  input wire logic [15:0] op_offset_in,
  input wire logic op_dual_in,
  input wire logic op_p3_dec_in,
  input wire logic mod_r1_en_in,
  // Normalization counter and conditional transfer
  input wire logic norm_en_in,
  input wire logic norm_dec_in,
  input wire logic [2:0] norm_ptr_in,
  input wire logic tcc_en_in,
  input wire logic tcc_true_in,
  input wire logic [2:0] tcc_src_in,
  input wire logic [2:0] tcc_dst_in,
  // Address buses
  output logic [15:0] primary_data_addr_bus_out,
  output logic primary_addr_valid_out,
  output logic [15:0] secondary_data_addr_bus_out,
  output logic secondary_addr_valid_out,
  output logic secondary_range_err_out,
  output logic [15:0] program_addr_bus_out,
  output logic program_addr_valid_out
);
  logic [15:0] ptr_cur [0:adgen_pkg::NUM_PTR-1];
  logic [15:0] offset_register;
  logic [15:0] modifier_register;
  logic pend_valid;
  logic [2:0] pend_sel;
  logic [15:0] pend_data;
  logic pend_commit;
  logic gdb_wr_go;
  logic op_go;
  logic dual_go;
  logic ptr_ok;
  logic [15:0] sel_ptr;
  logic [15:0] step;
  logic is_index;
  logic is_post;
  logic mod_use;
  logic [15:0] mod_result;
  logic [15:0] mod_mask;
  logic [15:0] p3_next;
  logic [15:0] next_addr;
  logic [15:0] tcc_val;
  logic [15:0] rd_val;
  logic mod_written;

  assign gdb_wr_go = instr_en_in && gdb_wr_en_in;
  assign op_go = instr_en_in && op_valid_in;
  assign ptr_ok = op_ptr_in <= adgen_pkg::SEL_STACK;
  assign sel_ptr = ptr_ok ? ptr_cur[op_ptr_in] : adgen_pkg::PTR_RESET;
  assign dual_go = op_go && op_dual_in && (op_target_in == adgen_pkg::TGT_XDATA);
  assign pend_commit = instr_en_in && pend_valid;
  assign tcc_val = (tcc_src_in <= adgen_pkg::SEL_STACK) ? ptr_cur[tcc_src_in]
                                                        : adgen_pkg::PTR_RESET;

  // Step selection for the modulo unit
  always_comb
  begin
    step = adgen_pkg::PTR_RESET;
    is_index = 1'b0;
    is_post = 1'b0;
    case (op_mode_in)
      adgen_pkg::MODE_POSTINC:
      begin
        step = adgen_pkg::STEP_INC;
        is_post = 1'b1;
      end
      adgen_pkg::MODE_POSTDEC:
      begin
        step = adgen_pkg::STEP_DEC;
        is_post = 1'b1;
      end
      adgen_pkg::MODE_POSTOFF:
      begin
        step = offset_register;
        is_post = 1'b1;
      end
      adgen_pkg::MODE_IDXREG:
      begin
        step = offset_register;
        is_index = 1'b1;
      end
      adgen_pkg::MODE_IDXSHORT:
      begin
        step = {{(adgen_pkg::ADDR_W - adgen_pkg::SHORT_W){op_offset_in[5]}},
                op_offset_in[5:0]};
        is_index = 1'b1;
      end
      adgen_pkg::MODE_IDXLONG:
      begin
        step = op_offset_in;
        is_index = 1'b1;
      end
      default:
      begin
        step = adgen_pkg::PTR_RESET;
      end
    endcase
  end

  // Modifier reaches pointer zero, and pointer one only when enabled
  assign mod_use = is_post && (modifier_register != adgen_pkg::MOD_LINEAR)
                   && ((op_ptr_in == adgen_pkg::SEL_PTR0)
                       || (op_ptr_in == 3'h1 && mod_r1_en_in));

  adgen_modulo u_modulo
  (
    .ptr_in(sel_ptr),
    .step_in(step),
    .modifier_in(modifier_register),
    .use_mod_in(mod_use),
    .result_out(mod_result),
    .mask_out(mod_mask)
  );

  adgen_incdec u_incdec
  (
    .ptr_in(ptr_cur[adgen_pkg::SEL_PTR3]),
    .dec_in(op_p3_dec_in),
    .result_out(p3_next)
  );

  // Post modes drive the old value; indexed modes drive the sum
  assign next_addr = is_index ? mod_result : sel_ptr;

  // Pointer file, one entry per pointer plus the stack pointer
  genvar i;
  generate
    for (i = 0; i < adgen_pkg::NUM_PTR; i++)
    begin : g_ptr
      logic [15:0] q;
      logic commit_hit;
      logic op_hit;
      logic id_hit;
      logic norm_hit;
      logic tcc_hit;
      assign commit_hit = pend_commit && (pend_sel == 3'(i));
      assign op_hit = op_go && is_post && (op_ptr_in == 3'(i));
      assign id_hit = dual_go && (i == adgen_pkg::SEL_PTR3);
      assign norm_hit = instr_en_in && norm_en_in && (norm_ptr_in == 3'(i));
      assign tcc_hit = instr_en_in && tcc_en_in && tcc_true_in && (tcc_dst_in == 3'(i));
      assign ptr_cur[i] = q;

      // Stack pointer has no useful reset value until software loads it
      always_ff @(posedge core_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
          q <= adgen_pkg::PTR_RESET;
        else if (commit_hit)
          q <= pend_data;
        else if (op_hit)
          q <= mod_result;
        else if (id_hit)
          q <= p3_next;
        else if (norm_hit)
          q <= q + (norm_dec_in ? adgen_pkg::STEP_DEC : adgen_pkg::STEP_INC);
        else if (tcc_hit)
          q <= tcc_val;
      end
    end
  endgenerate

  // Delayed landing of moved pointer, stack and modifier values
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pend_valid <= 1'b0;
      pend_sel <= adgen_pkg::SEL_NONE;
      pend_data <= adgen_pkg::PTR_RESET;
    end
    else if (instr_en_in)
    begin
      pend_valid <= gdb_wr_en_in && (gdb_sel_in <= adgen_pkg::SEL_STACK
                                     || gdb_sel_in == adgen_pkg::SEL_MODIFIER);
      pend_sel <= gdb_sel_in;
      pend_data <= gdb_wdata_in;
    end
  end

  // Offset register is usable on the next instruction
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      offset_register <= adgen_pkg::OFFSET_RESET;
    else if (gdb_wr_go && gdb_sel_in == adgen_pkg::SEL_OFFSET)
      offset_register <= gdb_wdata_in;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      modifier_register <= adgen_pkg::MOD_LINEAR;
    else if (pend_commit && pend_sel == adgen_pkg::SEL_MODIFIER)
      modifier_register <= pend_data;
  end

  // Register read over the core global data bus
  always_comb
  begin
    rd_val = adgen_pkg::PTR_RESET;
    if (gdb_sel_in <= adgen_pkg::SEL_STACK)
      rd_val = ptr_cur[gdb_sel_in];
    else if (gdb_sel_in == adgen_pkg::SEL_OFFSET)
      rd_val = offset_register;
    else if (gdb_sel_in == adgen_pkg::SEL_MODIFIER)
      rd_val = modifier_register;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      gdb_rdata_out <= adgen_pkg::PTR_RESET;
      gdb_rdata_valid_out <= 1'b0;
    end
    else
    begin
      gdb_rdata_out <= gdb_rd_en_in ? rd_val : adgen_pkg::PTR_RESET;
      gdb_rdata_valid_out <= gdb_rd_en_in;
    end
  end

  // Primary data and program address buses
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      primary_data_addr_bus_out <= adgen_pkg::PTR_RESET;
      primary_addr_valid_out <= 1'b0;
      program_addr_bus_out <= adgen_pkg::PTR_RESET;
      program_addr_valid_out <= 1'b0;
    end
    else
    begin
      primary_addr_valid_out <= op_go && op_target_in == adgen_pkg::TGT_XDATA;
      program_addr_valid_out <= op_go && op_target_in == adgen_pkg::TGT_PROG;
      if (op_go && op_target_in == adgen_pkg::TGT_XDATA)
        primary_data_addr_bus_out <= next_addr;
      if (op_go && op_target_in == adgen_pkg::TGT_PROG)
        program_addr_bus_out <= next_addr;
    end
  end

  // Secondary bus: pointer three, on-chip window only
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      secondary_data_addr_bus_out <= adgen_pkg::PTR_RESET;
      secondary_addr_valid_out <= 1'b0;
      secondary_range_err_out <= 1'b0;
    end
    else
    begin
      if (dual_go)
        secondary_data_addr_bus_out <= ptr_cur[adgen_pkg::SEL_PTR3];
      secondary_addr_valid_out <= dual_go
        && ptr_cur[adgen_pkg::SEL_PTR3] <= adgen_pkg::XDATA_ONCHIP_TOP;
      secondary_range_err_out <= dual_go
        && ptr_cur[adgen_pkg::SEL_PTR3] > adgen_pkg::XDATA_ONCHIP_TOP;
    end
  end

  // Tracks whether the modifier left its reset value by software
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      mod_written <= 1'b0;
    else if (pend_commit && pend_sel == adgen_pkg::SEL_MODIFIER)
      mod_written <= 1'b1;
  end

  a_mod_reset_linear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !mod_written |-> modifier_register == adgen_pkg::MOD_LINEAR)
    else $error("modifier left linear without a write");
  a_post_old_addr: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    op_go && is_post && op_target_in == adgen_pkg::TGT_XDATA
    |=> primary_addr_valid_out && primary_data_addr_bus_out == $past(sel_ptr))
    else $error("post-update did not drive old pointer");
  a_index_sum: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    op_go && op_mode_in == adgen_pkg::MODE_IDXLONG && op_target_in == adgen_pkg::TGT_XDATA
    |=> primary_data_addr_bus_out == $past(sel_ptr) + $past(op_offset_in))
    else $error("long index address wrong");
  a_index_no_wb: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    op_go && is_index && op_ptr_in == 3'h2 && !pend_commit && !norm_en_in && !tcc_en_in
    |=> $stable(ptr_cur[2]))
    else $error("indexed mode wrote back pointer");
  a_move_lands_late: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    gdb_wr_go && gdb_sel_in == 3'h1 ##1 (!instr_en_in)[*1] ##1 instr_en_in
    |=> ptr_cur[1] == $past(pend_data))
    else $error("moved pointer did not land");
  a_move_held: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    gdb_wr_go && gdb_sel_in == 3'h2 && !pend_commit && !op_go && !norm_en_in && !tcc_en_in
    |=> pend_valid && $stable(ptr_cur[2]))
    else $error("moved pointer landed too early");
  a_pop_decrement: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    op_go && op_mode_in == adgen_pkg::MODE_POSTDEC && op_ptr_in == adgen_pkg::SEL_STACK
    && !(pend_commit && pend_sel == adgen_pkg::SEL_STACK)
    |=> ptr_cur[4] == $past(ptr_cur[4]) - 16'h0001)
    else $error("stack pointer not post-decremented");
  a_dual_step: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    dual_go && op_ptr_in != adgen_pkg::SEL_PTR3 && !op_p3_dec_in
    && !(pend_commit && pend_sel == adgen_pkg::SEL_PTR3)
    |=> ptr_cur[3] == $past(ptr_cur[3]) + 16'h0001
        && secondary_data_addr_bus_out == $past(ptr_cur[3]))
    else $error("pointer three not stepped on dual read");
  a_sec_onchip: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    secondary_addr_valid_out |-> secondary_data_addr_bus_out <= adgen_pkg::XDATA_ONCHIP_TOP)
    else $error("secondary address off chip");
  a_modulo_window: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    op_go && mod_use && op_ptr_in == adgen_pkg::SEL_PTR0 && !pend_commit
    && (sel_ptr & mod_mask) <= modifier_register
    |=> (ptr_cur[0] & $past(mod_mask)) <= $past(modifier_register))
    else $error("modulo update left buffer window");
  a_prog_fetch: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    op_go && op_target_in == adgen_pkg::TGT_PROG
    |=> program_addr_valid_out && !primary_addr_valid_out)
    else $error("program data access not on program bus");
  a_gdb_readback: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    gdb_rd_en_in |=> gdb_rdata_valid_out && gdb_rdata_out == $past(rd_val))
    else $error("register read mismatch");

endmodule // adgen_core
`default_nettype wire

// ===== adgen_mem_model.sv
// Data and program memory address ports, seen from the memory side
`timescale 1ns/1ns
`default_nettype none
module adgen_mem_model
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Address buses from the unit
  input wire logic [15:0] primary_data_addr_bus_in,
  input wire logic primary_addr_valid_in,
  input wire logic [15:0] secondary_data_addr_bus_in,
  input wire logic secondary_addr_valid_in,
  input wire logic program_addr_valid_in,
  // Access counts and on-chip breach flag
  output logic [15:0] prim_hits_out,
  output logic [15:0] sec_hits_out,
  output logic [15:0] prog_hits_out,
  output logic offchip_out
);
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      prim_hits_out <= 16'h0000;
      sec_hits_out <= 16'h0000;
      prog_hits_out <= 16'h0000;
      offchip_out <= 1'b0;
    end
    else
    begin
      prim_hits_out <= prim_hits_out + 16'(primary_addr_valid_in);
      sec_hits_out <= sec_hits_out + 16'(secondary_addr_valid_in);
      prog_hits_out <= prog_hits_out + 16'(program_addr_valid_in);
      // Second read must stay on chip; sticky so a single slip is seen
      if (secondary_addr_valid_in && secondary_data_addr_bus_in > adgen_pkg::XDATA_ONCHIP_TOP)
        offchip_out <= 1'b1;
    end
  end
endmodule // adgen_mem_model
`default_nettype wire

// ===== tb_dsp_address_generation_unit.sv
// Self-checking bench for the address generation unit
`timescale 1ns/1ns
`default_nettype none
module tb_dsp_address_generation_unit;
  logic clk, rstn, ie, wr, rd, ov, dual, p3d, m1, nen, ndec, ten, ttr;
  logic [2:0] sel, mode, ptr, np, ts, td;
  logic [1:0] tgt;
  logic [15:0] wd, off;
  wire logic [15:0] rdat, pa, sa, ga, hp, hs, hg;
  wire logic rv, pv, sv, se, gv, offc;
  logic v_ie, v_wr, v_rd, v_ov, v_dual, v_p3d, v_m1, v_n, v_nd, v_t, v_tt;
  logic [2:0] v_sel, v_mode, v_ptr, v_np, v_ts, v_td;
  logic [1:0] v_tgt;
  logic [15:0] v_wd, v_off;
  logic [15:0] rg [0:6];
  logic pend_v;
  logic [2:0] pend_s;
  logic [15:0] pend_d, e_rd, e_pa, e_sa, e_ga;
  logic e_rv, e_pv, e_sv, e_se, e_gv;
  int err_count, tests_run, pv_n, sv_n, gv_n;
  logic [31:0] seed;

  adgen_core dut (.core_clk_in(clk), .rstn_in(rstn), .instr_en_in(ie), .gdb_wr_en_in(wr),
    .gdb_rd_en_in(rd), .gdb_sel_in(sel), .gdb_wdata_in(wd), .gdb_rdata_out(rdat),
    .gdb_rdata_valid_out(rv), .op_valid_in(ov), .op_mode_in(mode), .op_target_in(tgt),
    .op_ptr_in(ptr), .op_offset_in(off), .op_dual_in(dual), .op_p3_dec_in(p3d),
    .mod_r1_en_in(m1), .norm_en_in(nen), .norm_dec_in(ndec), .norm_ptr_in(np),
    .tcc_en_in(ten), .tcc_true_in(ttr), .tcc_src_in(ts), .tcc_dst_in(td),
    .primary_data_addr_bus_out(pa), .primary_addr_valid_out(pv),
    .secondary_data_addr_bus_out(sa), .secondary_addr_valid_out(sv),
    .secondary_range_err_out(se), .program_addr_bus_out(ga), .program_addr_valid_out(gv));
  adgen_mem_model mdl (.core_clk_in(clk), .rstn_in(rstn), .primary_data_addr_bus_in(pa),
    .primary_addr_valid_in(pv), .secondary_data_addr_bus_in(sa), .secondary_addr_valid_in(sv),
    .program_addr_valid_in(gv), .prim_hits_out(hp), .sec_hits_out(hs), .prog_hits_out(hg),
    .offchip_out(offc));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // Modulo window: mask covers bits up to the modifier msb
  function automatic logic [15:0] upd_fn(logic [15:0] b, int s, logic um, logic [15:0] m);
    logic [15:0] mask;
    int lo;
    mask = 16'h0000;
    for (int i = 0; i < 16; i++) if (m[i]) mask = 16'((32'h1 << (i + 1)) - 1);
    if (!um) return b + 16'(s);
    lo = int'(b & mask) + s;
    if (lo > int'(m)) lo -= int'(m) + 1;
    if (lo < 0) lo += int'(m) + 1;
    return (b & ~mask) | 16'(lo);
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apply();
    {ie, wr, rd, ov, dual, p3d, m1, nen, ndec, ten, ttr} =
      {v_ie, v_wr, v_rd, v_ov, v_dual, v_p3d, v_m1, v_n, v_nd, v_t, v_tt};
    {sel, mode, ptr, np, ts, td, tgt, wd, off} =
      {v_sel, v_mode, v_ptr, v_np, v_ts, v_td, v_tgt, v_wd, v_off};
  endtask

  // One cycle: drive, predict, compare, then back to idle values
  task automatic cyc();
    logic [15:0] nx [0:6];
    logic [15:0] b, a;
    int s;
    logic um;
    apply();
    e_rv = v_rd;
    e_rd = (v_rd && v_sel != 3'h7) ? rg[v_sel] : 16'h0000;
    {e_pv, e_sv, e_se, e_gv} = 4'h0;
    if (v_ie)
    begin
      nx = rg;
      if (v_t && v_tt) nx[v_td] = rg[v_ts];
      if (v_n) nx[v_np] = rg[v_np] + (v_nd ? 16'hFFFF : 16'h0001);
      if (v_ov)
      begin
        b = (v_ptr <= 3'h4) ? rg[v_ptr] : 16'h0000;
        if (v_dual && v_tgt == 2'h1)
        begin
          e_sv = (rg[3] <= 16'h07FF);
          e_se = !e_sv;
          e_sa = rg[3];
          nx[3] = rg[3] + (v_p3d ? 16'hFFFF : 16'h0001);
        end
        case (v_mode)
          3'h1: s = 1;
          3'h2: s = -1;
          3'h3, 3'h4: s = int'($signed(rg[5]));
          3'h5: s = int'($signed(v_off[5:0]));
          3'h6: s = int'($signed(v_off));
          default: s = 0;
        endcase
        um = v_mode inside {3'h1, 3'h2, 3'h3} && rg[6] != 16'hFFFF &&
          (v_ptr == 3'h0 || (v_ptr == 3'h1 && v_m1));
        a = (v_mode inside {3'h4, 3'h5, 3'h6}) ? b + 16'(s) : b;
        if (v_mode inside {3'h1, 3'h2, 3'h3} && v_ptr <= 3'h4)
          nx[v_ptr] = upd_fn(b, s, um, rg[6]);
        if (v_tgt == 2'h1) {e_pv, e_pa} = {1'b1, a};
        if (v_tgt == 2'h2) {e_gv, e_ga} = {1'b1, a};
      end
      if (pend_v) nx[pend_s] = pend_d;
      pend_v = 1'b0;
      if (v_wr && v_sel == 3'h5) nx[5] = v_wd;
      else if (v_wr && v_sel != 3'h7) {pend_v, pend_s, pend_d} = {1'b1, v_sel, v_wd};
      rg = nx;
    end
    pv_n += int'(e_pv);
    sv_n += int'(e_sv);
    gv_n += int'(e_gv);
    @(posedge clk);
    #1;
    chk(16'(rv), 16'(e_rv));
    chk(rdat, e_rd);
    chk(16'(pv), 16'(e_pv));
    chk(pa, e_pa);
    chk(16'(sv), 16'(e_sv));
    chk(16'(se), 16'(e_se));
    if (e_sv) chk(sa, e_sa);
    chk(16'(gv), 16'(e_gv));
    chk(ga, e_ga);
    {v_ie, v_wr, v_rd, v_ov, v_dual, v_p3d, v_n, v_nd, v_t, v_tt} = 10'h000;
    {v_sel, v_mode, v_ptr, v_np, v_ts, v_td, v_tgt} = 20'h00000;
    v_wd = rnd();
    v_off = rnd();
  endtask

  task automatic rdr(logic [2:0] s);
    v_rd = 1'b1;
    v_sel = s;
    cyc();
  endtask

  task automatic wrr(logic [2:0] s, logic [15:0] d);
    {v_ie, v_wr, v_sel, v_wd} = {2'b11, s, d};
    cyc();
  endtask

  task automatic op(logic [2:0] m, logic [1:0] t, logic [2:0] p, logic [15:0] o);
    {v_ie, v_ov, v_mode, v_tgt, v_ptr, v_off} = {2'b11, m, t, p, o};
    cyc();
  endtask

  task automatic nop();
    v_ie = 1'b1;
    cyc();
  endtask

  task automatic rd_all();
    for (int i = 0; i < 8; i++) rdr(3'(i));
  endtask

  task automatic give_verdict();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    seed = 32'd7855;
    {err_count, tests_run, pv_n, sv_n, gv_n} = '0;
    {v_ie, v_wr, v_rd, v_ov, v_dual, v_p3d, v_m1, v_n, v_nd, v_t, v_tt} = 11'h000;
    {v_sel, v_mode, v_ptr, v_np, v_ts, v_td, v_tgt, v_wd, v_off} = 52'h0;
    rg = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF};
    {pend_v, pend_s, pend_d, e_pa, e_ga, e_sa} = '0;
    apply();
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    rd_all();
    $display("test 1 done");
    // Staged move must not reach the very next instruction
    for (int i = 0; i < 6; i++) wrr(3'(i), rnd());
    op(3'h0, 2'h1, 3'h5, 16'h0000);
    wrr(3'h1, rnd());
    op(3'h0, 2'h1, 3'h1, 16'h0000);
    op(3'h0, 2'h1, 3'h1, 16'h0000);
    // Staged moves stay hidden from reads until the following instruction ends
    wrr(3'h2, rnd());
    rdr(3'h2);
    nop();
    wrr(3'h1, rnd());
    rdr(3'h1);
    nop();
    rd_all();
    $display("test 2 done");
    for (int m = 0; m < 8; m++)
      for (int t = 0; t < 4; t++) op(3'(m), 2'(t), 3'(rnd() % 5), rnd());
    rd_all();
    $display("test 3 done");
    wrr(3'h3, 16'h07FE);
    nop();
    v_dual = 1'b1;
    op(3'h1, 2'h1, 3'h0, 16'h0000);
    v_dual = 1'b1;
    op(3'h2, 2'h1, 3'h1, 16'h0000);
    v_dual = 1'b1;
    op(3'h0, 2'h1, 3'h2, 16'h0000);
    wrr(3'h3, 16'h0001);
    nop();
    repeat (2)
    begin
      {v_dual, v_p3d} = 2'b11;
      op(3'h1, 2'h1, 3'h2, 16'h0000);
    end
    rd_all();
    $display("test 4 done");
    wrr(3'h6, 16'h0007);
    wrr(3'h0, 16'h0106);
    wrr(3'h5, 16'h0003);
    wrr(3'h1, 16'h0205);
    wrr(3'h2, 16'h0307);
    nop();
    repeat (3) op(3'h1, 2'h1, 3'h0, 16'h0000);
    repeat (3) op(3'h2, 2'h1, 3'h0, 16'h0000);
    op(3'h3, 2'h1, 3'h0, 16'h0000);
    op(3'h1, 2'h1, 3'h1, 16'h0000);
    v_m1 = 1'b1;
    repeat (3) op(3'h1, 2'h1, 3'h1, 16'h0000);
    op(3'h1, 2'h1, 3'h2, 16'h0000);
    v_m1 = 1'b0;
    rd_all();
    $display("test 5 done");
    {v_n, v_np} = {1'b1, 3'h2};
    nop();
    {v_n, v_nd, v_np} = {2'b11, 3'h0};
    nop();
    {v_t, v_tt, v_ts, v_td} = {2'b11, 3'h0, 3'h3};
    nop();
    {v_t, v_tt, v_ts, v_td} = {2'b10, 3'h1, 3'h2};
    nop();
    rd_all();
    $display("test 6 done");
    wrr(3'h4, 16'h0100);
    nop();
    repeat (2) op(3'h1, 2'h1, 3'h4, 16'h0000);
    op(3'h2, 2'h1, 3'h4, 16'h0000);
    op(3'h2, 2'h2, 3'h4, 16'h0000);
    rd_all();
    chk(hp, 16'(pv_n));
    chk(hs, 16'(sv_n));
    chk(hg, 16'(gv_n));
    chk(16'(offc), 16'h0000);
    $display("test 7 done");
    give_verdict();
  end
endmodule // tb_dsp_address_generation_unit
`default_nettype wire
